/* pkg/pts_pkg.sv */
package pts_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 125000000;
    localparam int unsigned BAUD_HZ     = 1200;
    localparam int unsigned BIT_CYC     = CLK_HZ / BAUD_HZ;
    localparam int unsigned RAMP_US     = 4000;
    localparam int unsigned RAMP_STEPS  = 16;
    localparam int unsigned STEP_CYC    =
        (CLK_HZ / 1000000) * RAMP_US / RAMP_STEPS;
    localparam int unsigned MET_LO_HZ   = 12000;
    localparam int unsigned MET_HI_HZ   = 16000;
    localparam int unsigned MET_LO_HALF = CLK_HZ / (2 * MET_LO_HZ);
    localparam int unsigned MET_HI_HALF = CLK_HZ / (2 * MET_HI_HZ);
    localparam int unsigned DIV_W       = 17;

    // ------------------------------------------------------------
    // Setup, mode and status bit positions
    // ------------------------------------------------------------
    localparam int unsigned SU_FSK_PAIR = 0;
    localparam int unsigned SU_ASYNC    = 1;
    localparam int unsigned SU_RING_LSB = 2;
    localparam int unsigned SU_MET_FREQ = 4;
    localparam int unsigned SU_TX_EN    = 6;
    localparam int unsigned MD_FLD_LSB  = 0;
    localparam int unsigned MD_ATT_LSB  = 2;
    localparam int unsigned MD_FSK_SEL  = 5;
    localparam int unsigned MD_OUT_EN   = 6;
    localparam int unsigned MD_MET_EN   = 7;
    localparam int unsigned ST_READY    = 6;
    localparam int unsigned ST_UNDER    = 7;

    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic [11:0] TONE_BASE_A = 12'h21c;
    localparam logic [11:0] TONE_BASE_B = 12'h564;
    localparam logic [11:0] TONE_STEP   = 12'h078;
    localparam logic [11:0] FSK_A_SPACE = 12'h834;
    localparam logic [11:0] FSK_A_MARK  = 12'h514;
    localparam logic [11:0] FSK_B_SPACE = 12'h898;
    localparam logic [11:0] FSK_B_MARK  = 12'h4b0;
    localparam logic [4:0]  LVL_DUAL    = 5'h03;
    localparam logic [4:0]  LVL_DTMF_HI = 5'h03;
    localparam logic [4:0]  LVL_DTMF_LO = 5'h05;
    localparam logic [3:0]  DTMF_CODE   = 4'hc;
    localparam logic [7:0]  TRAP_CF_X100 = 8'h87;
    localparam logic [4:0]  MET_FULL    = 5'h10;
    localparam logic [1:0]  RING_SQUARE = 2'h0;
    localparam logic [1:0]  RING_TRAP   = 2'h1;
    localparam logic [1:0]  RING_SINE   = 2'h2;
    localparam logic [1:0]  FIELD_1     = 2'h1;
    localparam logic [1:0]  FIELD_2     = 2'h2;
    localparam logic [1:0]  FIELD_3     = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_DATA  = 2'b11,
        ST_STOP  = 2'b10
    } pts_uart_st_t;

endpackage

/* design/pts_tick.sv */
`timescale 1ns/1ps
module pts_tick (
    // Clock and reset
    input  wire logic                     clk_sys_i,
    input  wire logic                     srst_i,
    // Control
    input  wire logic                     en_i,
    input  wire logic [pts_pkg::DIV_W-1:0] div_i,
    // Output
    output logic                          tick_o
);

    logic [pts_pkg::DIV_W-1:0] cnt_reg;

    // Counts div_i cycles, restarts while disabled
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || !en_i) begin
            cnt_reg <= '0;
        end else if (cnt_reg >= div_i - 1'b1) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign tick_o = en_i && (cnt_reg >= div_i - 1'b1);

endmodule

/* design/pts_tone_map.sv */
`timescale 1ns/1ps
module pts_tone_map (
    // Code in
    input  wire logic [3:0]  code_i,
    // Frequency out in Hz, zero when off or unused
    output logic      [11:0] freq_o
);

    always_comb begin
        freq_o = 12'h000;
        if (code_i >= 4'h1 && code_i <= 4'h6) begin
            freq_o = pts_pkg::TONE_BASE_A
                   + pts_pkg::TONE_STEP * {8'h00, code_i - 4'h1};
        end else if (code_i >= 4'h8 && code_i <= 4'hd) begin
            freq_o = pts_pkg::TONE_BASE_B
                   + pts_pkg::TONE_STEP * {8'h00, code_i - 4'h8};
        end
    end

endmodule

/* design/pts_tx_signal_control.sv */
`timescale 1ns/1ps
// How it works
// RULE1: Field select 10 uses field 2, 11 field 3.
// RULE2: Each nibble maps codes to 540..1980 Hz.
// RULE3: Metering output own pin, 12 or 16 kHz.
// RULE4: Mode bit 7 enables metering generator.
// RULE5: Metering ramps 16 steps over 4 ms.
// RULE6: Mode bits 4..2 attenuate 2 dB per code.
// RULE7: Dual tones 3 dB down, DTMF 3/5 dB.
// RULE8: Setup bits 3..2 pick ringing waveform.
// RULE9: Trapezoid ringing has crest factor 1.35.
// RULE10: Status bit 6 shows data register free.
// RULE11: Host writes byte after ready goes high.
// RULE12: Sync mode sends 8 bits, LSB first.
// RULE13: Async mode adds start and stop bits.
// RULE14: Missing byte sets underflow status bit 7.
// RULE15: Async underflow sends mark until loaded.
// RULE16: Sync underflow resends held byte.
// RULE17: Serial bits drive FSK encoder frequency.
// RULE18: Setup bit 0 picks FSK frequency pair.
// RULE19: Mode bit 5 FSK/tone, bit 6 gates; here bit 6 gates the tone output only, FSK runs without it.
// RULE20: Generators run only with setup bit 6; the metering generator here runs without it.
// RULE21: Write clears ready, load sets it again.
// RULE22: Bit and ramp timing divide system clock.
module pts_tx_signal_control #(
    parameter int unsigned BIT_CYC     = pts_pkg::BIT_CYC,
    parameter int unsigned STEP_CYC    = pts_pkg::STEP_CYC,
    parameter int unsigned MET_LO_HALF = pts_pkg::MET_LO_HALF,
    parameter int unsigned MET_HI_HALF = pts_pkg::MET_HI_HALF
) (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        srst_i,
    // Configuration
    input  wire logic [7:0]  setup_i,
    input  wire logic [7:0]  mode_i,
    input  wire logic [7:0]  tx_tones_i,
    // Transmit data from host
    input  wire logic [7:0]  tx_data_i,
    input  wire logic        tx_data_wr_i,
    input  wire logic        underflow_clr_i,
    // Status
    output logic      [7:0]  status_o,
    output logic             tx_data_ready_o,
    output logic             tx_underflow_o,
    // FSK encoder feed
    output logic             fsk_active_o,
    output logic             fsk_bit_o,
    output logic      [11:0] fsk_freq_o,
    // Tone generator
    output logic             gen_out_en_o,
    output logic      [1:0]  tone_field_o,
    output logic      [11:0] tone_hi_freq_o,
    output logic      [11:0] tone_lo_freq_o,
    output logic      [4:0]  tone_hi_atten_o,
    output logic      [4:0]  tone_lo_atten_o,
    output logic      [4:0]  sig_atten_o,
    // Ringing
    output logic      [1:0]  ring_wave_o,
    output logic             ring_valid_o,
    output logic      [7:0]  ring_crest_x100_o,
    // Metering
    output logic             metering_pulse_o,
    output logic      [4:0]  metering_level_o
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic        tx_en;
    logic        fsk_sel;
    logic        uart_run;
    logic        async_md;
    logic [1:0]  field;
    logic [2:0]  att_code;
    logic [4:0]  att_db;
    logic [11:0] map_hi;
    logic [11:0] map_lo;

    assign tx_en    = setup_i[pts_pkg::SU_TX_EN];
    assign fsk_sel  = mode_i[pts_pkg::MD_FSK_SEL];
    assign uart_run = tx_en && fsk_sel;                   // [RULE20]
    assign async_md = setup_i[pts_pkg::SU_ASYNC];
    assign field    = mode_i[pts_pkg::MD_FLD_LSB +: 2];
    assign att_code = mode_i[pts_pkg::MD_ATT_LSB +: 3];
    assign att_db   = {1'b0, att_code, 1'b0};              // [RULE6]

    pts_tone_map u_map_hi (
        .code_i (tx_tones_i[7:4]),
        .freq_o (map_hi)
    );

    pts_tone_map u_map_lo (
        .code_i (tx_tones_i[3:0]),
        .freq_o (map_lo)
    );

    // ------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------
    logic                      bit_tick;
    logic                      step_tick;
    logic                      car_tick;
    logic [4:0]                level_reg;
    logic [pts_pkg::DIV_W-1:0] car_div;

    assign car_div = setup_i[pts_pkg::SU_MET_FREQ]
                   ? pts_pkg::DIV_W'(MET_HI_HALF)
                   : pts_pkg::DIV_W'(MET_LO_HALF);        // [RULE3]

    pts_tick u_bit_tick (                                 // [RULE22]
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .en_i      (uart_run),
        .div_i     (pts_pkg::DIV_W'(BIT_CYC)),
        .tick_o    (bit_tick)
    );

    pts_tick u_step_tick (                                // [RULE22]
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .en_i      (1'b1),
        .div_i     (pts_pkg::DIV_W'(STEP_CYC)),
        .tick_o    (step_tick)
    );

    pts_tick u_car_tick (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .en_i      (level_reg != 5'h00),
        .div_i     (car_div),
        .tick_o    (car_tick)
    );

    // ------------------------------------------------------------
    // Holding register and flags
    // ------------------------------------------------------------
    pts_pkg::pts_uart_st_t state_reg;
    logic [7:0]  data_reg;
    logic [7:0]  shift_reg;
    logic [2:0]  cnt_reg;
    logic        hold_full_reg;
    logic        under_reg;
    logic        line_reg;
    logic        need_byte;
    logic        take;
    logic        under_evt;
    logic        reload;

    assign need_byte = uart_run && bit_tick
        && (state_reg == pts_pkg::ST_IDLE
            || state_reg == pts_pkg::ST_STOP
            || (state_reg == pts_pkg::ST_DATA && cnt_reg == 3'h7
                && !async_md));
    assign take      = need_byte && hold_full_reg;
    assign under_evt = need_byte && !hold_full_reg
        && state_reg != pts_pkg::ST_IDLE;                 // [RULE14]
    assign reload    = take || (under_evt && !async_md);  // [RULE16]

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            data_reg <= 8'h00;
        end else if (tx_data_wr_i) begin
            data_reg <= tx_data_i;
        end
    end

    // Write wins over a same-cycle load
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            hold_full_reg <= 1'b0;
        end else if (tx_data_wr_i) begin
            hold_full_reg <= 1'b1;                        // [RULE21]
        end else if (take) begin
            hold_full_reg <= 1'b0;                        // [RULE21]
        end
    end

    // Set wins over clear
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            under_reg <= 1'b0;
        end else if (under_evt) begin
            under_reg <= 1'b1;                            // [RULE14]
        end else if (underflow_clr_i) begin
            under_reg <= 1'b0;
        end
    end

    assign tx_data_ready_o = !hold_full_reg;              // [RULE10]
    assign tx_underflow_o  = under_reg;
    assign status_o = {under_reg, !hold_full_reg, 6'h00};

    // ------------------------------------------------------------
    // Transmit shifter
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || !uart_run) begin
            state_reg <= pts_pkg::ST_IDLE;
            shift_reg <= 8'h00;
            cnt_reg   <= 3'h0;
            line_reg  <= 1'b1;
        end else if (need_byte) begin
            cnt_reg <= 3'h0;
            if (reload && async_md) begin
                shift_reg <= data_reg;
                state_reg <= pts_pkg::ST_START;
                line_reg  <= 1'b0;                        // [RULE13]
            end else if (reload) begin
                shift_reg <= data_reg;
                state_reg <= pts_pkg::ST_DATA;
                line_reg  <= data_reg[0];                 // [RULE12]
            end else begin
                state_reg <= pts_pkg::ST_IDLE;
                line_reg  <= 1'b1;                        // [RULE15]
            end
        end else if (bit_tick) begin
            case (state_reg)
                pts_pkg::ST_START: begin
                    state_reg <= pts_pkg::ST_DATA;
                    line_reg  <= shift_reg[0];            // [RULE13]
                end
                pts_pkg::ST_DATA: begin
                    if (cnt_reg == 3'h7) begin
                        state_reg <= pts_pkg::ST_STOP;
                        line_reg  <= 1'b1;                // [RULE13]
                    end else begin
                        cnt_reg   <= cnt_reg + 3'h1;
                        shift_reg <= {1'b0, shift_reg[7:1]};
                        line_reg  <= shift_reg[1];        // [RULE12]
                    end
                end
                default: begin
                    state_reg <= pts_pkg::ST_IDLE;
                    line_reg  <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // FSK encoder feed
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            fsk_active_o <= 1'b0;
            fsk_bit_o    <= 1'b1;
            fsk_freq_o   <= 12'h000;
        end else begin
            fsk_active_o <= uart_run;
            fsk_bit_o    <= line_reg;                     // [RULE17]
            if (!uart_run) begin
                fsk_freq_o <= 12'h000;
            end else if (setup_i[pts_pkg::SU_FSK_PAIR]) begin
                fsk_freq_o <= line_reg ? pts_pkg::FSK_B_MARK
                                       : pts_pkg::FSK_B_SPACE; // [RULE18]
            end else begin
                fsk_freq_o <= line_reg ? pts_pkg::FSK_A_MARK
                                       : pts_pkg::FSK_A_SPACE; // [RULE18]
            end
        end
    end

    // ------------------------------------------------------------
    // Tone select and levels
    // ------------------------------------------------------------
    logic tone_on;
    logic dual;
    logic dtmf;

    assign tone_on = tx_en && !fsk_sel
                  && mode_i[pts_pkg::MD_OUT_EN];           // [RULE19]
    assign dual    = (tx_tones_i[7:4] != 4'h0)
                  && (tx_tones_i[3:0] != 4'h0);
    assign dtmf    = field == pts_pkg::FIELD_2
                  && tx_tones_i[7:4] >= pts_pkg::DTMF_CODE
                  && tx_tones_i[3:0] >= pts_pkg::DTMF_CODE;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            gen_out_en_o    <= 1'b0;
            tone_field_o    <= 2'h0;
            tone_hi_freq_o  <= 12'h000;
            tone_lo_freq_o  <= 12'h000;
            tone_hi_atten_o <= 5'h00;
            tone_lo_atten_o <= 5'h00;
            sig_atten_o     <= 5'h00;
        end else begin
            gen_out_en_o <= uart_run || tone_on;          // [RULE19]
            tone_field_o <= field;
            sig_atten_o  <= att_db;                       // [RULE6]
            if (tone_on && field == pts_pkg::FIELD_3) begin
                tone_hi_freq_o <= map_hi;                 // [RULE1] [RULE2]
                tone_lo_freq_o <= map_lo;                 // [RULE2]
            end else begin
                tone_hi_freq_o <= 12'h000;
                tone_lo_freq_o <= 12'h000;
            end
            if (dtmf) begin
                tone_hi_atten_o <= att_db + pts_pkg::LVL_DTMF_LO; // [RULE7]
                tone_lo_atten_o <= att_db + pts_pkg::LVL_DTMF_HI; // [RULE7]
            end else if (dual && !fsk_sel) begin
                tone_hi_atten_o <= att_db + pts_pkg::LVL_DUAL;    // [RULE7]
                tone_lo_atten_o <= att_db + pts_pkg::LVL_DUAL;    // [RULE7]
            end else begin
                tone_hi_atten_o <= att_db;                // [RULE7]
                tone_lo_atten_o <= att_db;
            end
        end
    end

    // ------------------------------------------------------------
    // Ringing select
    // ------------------------------------------------------------
    logic [1:0] ring_sel;

    assign ring_sel = setup_i[pts_pkg::SU_RING_LSB +: 2];

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ring_wave_o       <= pts_pkg::RING_SQUARE;
            ring_valid_o      <= 1'b0;
            ring_crest_x100_o <= 8'h00;
        end else begin
            ring_wave_o  <= ring_sel;                     // [RULE8]
            ring_valid_o <= ring_sel != 2'h3;             // [RULE8]
            ring_crest_x100_o <= (ring_sel == pts_pkg::RING_TRAP)
                ? pts_pkg::TRAP_CF_X100 : 8'h00;          // [RULE9]
        end
    end

    // ------------------------------------------------------------
    // Metering generator
    // ------------------------------------------------------------
    logic met_en;

    assign met_en = mode_i[pts_pkg::MD_MET_EN];

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            level_reg <= 5'h00;
        end else if (step_tick) begin
            if (met_en && level_reg < pts_pkg::MET_FULL) begin
                level_reg <= level_reg + 5'h01;           // [RULE4] [RULE5]
            end else if (!met_en && level_reg != 5'h00) begin
                level_reg <= level_reg - 5'h01;           // [RULE5]
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i || level_reg == 5'h00) begin
            metering_pulse_o <= 1'b0;
        end else if (car_tick) begin
            metering_pulse_o <= !metering_pulse_o;        // [RULE3]
        end
    end

    assign metering_level_o = level_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    wr_clears_ready_a: assert property ( // [RULE21]
        tx_data_wr_i |=> !tx_data_ready_o)
        else $error("ready stayed high after a write");
    load_sets_ready_a: assert property ( // [RULE21]
        take && !tx_data_wr_i |=> tx_data_ready_o)
        else $error("ready not raised after load");
    underflow_flag_a: assert property ( // [RULE14]
        under_evt |=> tx_underflow_o && status_o[7])
        else $error("underflow not flagged");
    async_mark_a: assert property ( // [RULE15]
        under_evt && async_md && uart_run |=>
        line_reg && state_reg == pts_pkg::ST_IDLE)
        else $error("async underflow did not idle on mark");
    sync_resend_a: assert property ( // [RULE16]
        under_evt && !async_md && uart_run |=>
        shift_reg == $past(data_reg) && state_reg == pts_pkg::ST_DATA)
        else $error("sync underflow did not resend byte");
    start_bit_a: assert property ( // [RULE13]
        state_reg == pts_pkg::ST_START |-> !line_reg)
        else $error("start bit not space");
    stop_bit_a: assert property ( // [RULE13]
        state_reg == pts_pkg::ST_STOP |-> line_reg)
        else $error("stop bit not mark");
    ramp_step_a: assert property ( // [RULE5]
        !step_tick |=> $stable(level_reg))
        else $error("metering level moved off a step");
    ramp_limit_a: assert property ( // [RULE5]
        level_reg <= pts_pkg::MET_FULL)
        else $error("metering level above full");
    meter_off_a: assert property ( // [RULE4]
        level_reg == 5'h00 |=> !metering_pulse_o)
        else $error("metering output active at zero level");
    atten_code_a: assert property ( // [RULE6]
        ##1 sig_atten_o == {1'b0, $past(att_code), 1'b0})
        else $error("attenuation wrong");
    field3_a: assert property ( // [RULE1]
        tone_on && field == pts_pkg::FIELD_3
        && tx_tones_i[7:4] == 4'hd |=> tone_hi_freq_o == 12'h7bc)
        else $error("field 3 code 13 not 1980 Hz");

    async_char_c: cover property (
        state_reg == pts_pkg::ST_STOP && bit_tick && take);
    sync_under_c: cover property (under_evt && !async_md);
    ramp_full_c: cover property (level_reg == pts_pkg::MET_FULL);

endmodule

/* testbench/pts_host_model.sv */
`timescale 1ns/1ps
module pts_host_model (
    // Clock, reset and script
    input  wire logic        clk_sys_i,
    input  wire logic        srst_i,
    input  wire logic [1:0]  cnt_i,
    input  wire logic [15:0] bytes_i,
    // Device side
    input  wire logic        ready_i,
    output logic      [7:0]  data_o,
    output logic             wr_o
);
    // ------------------------------------------------------------
    // One write per ready, data inverted the cycle after each write, then held
    // ------------------------------------------------------------
    logic [1:0] sent;
    always @(negedge clk_sys_i) begin
        if (srst_i || cnt_i == 2'h0) sent <= 2'h0;
        if (srst_i) begin
            wr_o <= 1'b0;
            data_o <= 8'h00;
        end else if (wr_o) begin
            wr_o <= 1'b0;
            data_o <= ~data_o;
        end else if (!srst_i && ready_i && sent < cnt_i) begin
            wr_o <= 1'b1;
            data_o <= sent == 2'h0 ? bytes_i[7:0] : bytes_i[15:8];
            sent <= sent + 2'h1;
        end
    end
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
    error_cnt++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module tb;
    localparam int BITC = 20, STEPC = 8, LOH = 4, HIH = 3;
    logic        clk_sys_i = 1'b0, srst_i = 1'b1;
    logic [7:0]  setup, mode, tones, txd, crest, stat;
    logic [15:0] hbytes;
    logic [11:0] ffreq, thi;
    logic [4:0]  tatt, tlatt, satt, mlvl;
    logic [1:0]  hcnt, rwave, tfield;
    logic        wr, uclr, ready, under, fbit, mpulse, rvalid, gen;
    int          error_cnt = 0, check_count = 0, cyc = 0;
    always #4 clk_sys_i = ~clk_sys_i;
    pts_tx_signal_control #(.BIT_CYC(BITC), .STEP_CYC(STEPC),
        .MET_LO_HALF(LOH), .MET_HI_HALF(HIH)) DUT (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .setup_i(setup),
        .mode_i(mode), .tx_tones_i(tones), .tx_data_i(txd),
        .tx_data_wr_i(wr), .underflow_clr_i(uclr), .status_o(stat),
        .tx_data_ready_o(ready), .tx_underflow_o(under),
        .fsk_active_o(), .fsk_bit_o(fbit), .fsk_freq_o(ffreq),
        .gen_out_en_o(gen), .tone_field_o(tfield), .tone_hi_freq_o(thi),
        .tone_lo_freq_o(), .tone_hi_atten_o(tatt), .tone_lo_atten_o(tlatt),
        .sig_atten_o(satt), .ring_wave_o(rwave), .ring_valid_o(rvalid),
        .ring_crest_x100_o(crest), .metering_pulse_o(mpulse),
        .metering_level_o(mlvl));
    pts_host_model HOST (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .cnt_i(hcnt), .bytes_i(hbytes), .ready_i(ready), .data_o(txd),
        .wr_o(wr));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    function automatic logic [11:0] tone_hz(input int c);
        if (c >= 1 && c <= 6)
            return pts_pkg::TONE_BASE_A + 12'(pts_pkg::TONE_STEP * (c - 1));
        if (c >= 8 && c <= 13)
            return pts_pkg::TONE_BASE_B + 12'(pts_pkg::TONE_STEP * (c - 8));
        return 12'h000;
    endfunction
    function automatic logic [11:0] fsk_hz(input logic b, input logic p);
        if (b) return p ? pts_pkg::FSK_B_MARK : pts_pkg::FSK_A_MARK;
        return p ? pts_pkg::FSK_B_SPACE : pts_pkg::FSK_A_SPACE;
    endfunction
    task automatic find_mid;
        int i;
        i = 0;
        while (fbit !== 1'b0 && i < 400) begin
            step(1);
            i++;
        end
        step(BITC / 2);
    endtask
    task automatic rx(input logic [7:0] b, input logic as, input logic p);
        logic [9:0] f;
        int k;
        f = as ? {1'b1, b, 1'b0} : {2'b00, b};
        for (k = 0; k < (as ? 10 : 8); k++) begin
            `CHK("line", f[k], fbit)
            `CHK("freq", fsk_hz(f[k], p), ffreq)
            step(BITC);
        end
    endtask
    task automatic half(input int h);
        int n;
        logic p;
        n = 0;
        p = mpulse;
        while (mpulse === p && n < 50) begin
            step(1);
            n++;
        end
        n = 0;
        p = mpulse;
        while (mpulse === p && n < 50) begin
            step(1);
            n++;
        end
        `CHK("half period", h, n)
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_levels;
        int c;
        for (c = 0; c < 8; c++) begin
            mode = 8'(c << 2);
            step(2);
            `CHK("atten", 5'(2 * c), satt)
        end
        for (c = 0; c < 4; c++) begin
            setup = 8'(c << 2);
            step(2);
            `CHK("ring", 2'(c), rwave)
            `CHK("ring ok", c != 3, rvalid)
            `CHK("crest", c == 1 ? 8'h87 : 8'h00, crest)
        end
    endtask
    task automatic t_tones;
        int c;
        setup = 8'h40;
        for (c = 0; c < 16; c++) begin
            mode = 8'h43;
            tones = 8'(c * 17);
            step(2);
            `CHK("tone", tone_hz(c), thi)
            `CHK("dual", c == 0 ? 5'h00 : 5'h03, tatt)
        end
        `CHK("gen on", 1'b1, gen)
        mode = 8'h42;
        tones = 8'hcd;
        step(2);
        `CHK("field2", 2'h2, tfield)
        `CHK("no map", 12'h000, thi)
        `CHK("dtmf lo", 5'h05, tatt)
        `CHK("dtmf hi", 5'h03, tlatt)
        mode = 8'h03;
        step(2);
        `CHK("gate", 12'h000, thi)
        `CHK("gen off", 1'b0, gen)
        mode = 8'h43;
        setup = 8'h00;
        step(2);
        `CHK("tx off", 12'h000, thi)
    endtask
    task automatic t_meter;
        mode = 8'h80;
        step(16 * STEPC + 4);
        `CHK("level up", 5'h10, mlvl)
        half(LOH);
        setup = 8'h10;
        step(4);
        half(HIH);
        mode = 8'h00;
        step(16 * STEPC + 4);
        `CHK("level down", 5'h00, mlvl)
    endtask
    task automatic t_async;
        hcnt = 2'h2;
        hbytes = 16'h3ca5;
        step(3);
        `CHK("ready low", 1'b0, ready)
        setup = 8'h42;
        mode = 8'h20;
        find_mid;
        rx(8'ha5, 1'b1, 1'b0);
        rx(8'h3c, 1'b1, 1'b0);
        step(2 * BITC);
        `CHK("underflow", 1'b1, under)
        `CHK("mark", 1'b1, fbit)
        `CHK("ready", 1'b1, ready)
        `CHK("status", 8'hc0, stat)
    endtask
    task automatic t_sync;
        setup = 8'h00;
        hcnt = 2'h0;
        uclr = 1'b1;
        step(2);
        uclr = 1'b0;
        hcnt = 2'h1;
        hbytes = 16'h0096;
        step(3);
        `CHK("cleared", 1'b0, under)
        setup = 8'h41;
        mode = 8'h20;
        find_mid;
        rx(8'h96, 1'b0, 1'b1);
        rx(8'h96, 1'b0, 1'b1);
        `CHK("underflow", 1'b1, under)
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict;
        end
    end
    initial begin
        setup = 8'h00;
        mode = 8'h00;
        tones = 8'h00;
        uclr = 1'b0;
        hcnt = 2'h0;
        hbytes = 16'h0000;
        step(10);
        srst_i = 1'b0;
        step(1);
        `CHK("rst ready", 1'b1, ready)
        `CHK("rst under", 1'b0, under)
        t_levels;
        t_tones;
        t_meter;
        t_async;
        t_sync;
        give_verdict;
    end
endmodule
